// file: common/spi_port_pkg.sv
`default_nettype none

package spi_port_pkg;

   // ----------------------------------------------------------------
   // register bus
   // ----------------------------------------------------------------
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              we;
      logic              re;
   } bus_req_t;

   localparam logic [ADDR_W-1:0] OFF_CTRL = 4'h0;
   localparam logic [ADDR_W-1:0] OFF_STAT = 4'h1;
   localparam logic [ADDR_W-1:0] OFF_BUF  = 4'h2;
   localparam logic [ADDR_W-1:0] OFF_IRQ  = 4'h3;

   // ----------------------------------------------------------------
   // field positions and reset values
   // ----------------------------------------------------------------
   localparam int CTRL_WRITE_COLLISION_FLAG = 7;
   localparam int CTRL_OVF  = 6;
   localparam int CTRL_EN   = 5;
   localparam int CTRL_CKP  = 4;
   localparam int STAT_SMP  = 7;
   localparam int STAT_CKE  = 6;
   localparam int STAT_BF   = 0;
   localparam int IRQ_PORT  = 3;

   localparam logic [DATA_W-1:0] CTRL_RST = 8'h00;
   localparam logic [DATA_W-1:0] BUF_RST  = 8'h00;

   // ----------------------------------------------------------------
   // mode codes and rate dividers
   // ----------------------------------------------------------------
   localparam logic [3:0] MODE_DIV4  = 4'h0;
   localparam logic [3:0] MODE_DIV16 = 4'h1;
   localparam logic [3:0] MODE_DIV64 = 4'h2;
   localparam logic [3:0] MODE_TMR2  = 4'h3;

   localparam int DIV_W = 5;
   localparam int FOSC_DIV4  = 4;
   localparam int FOSC_DIV16 = 16;
   localparam int FOSC_DIV64 = 64;
   localparam logic [DIV_W-1:0] RELOAD_DIV4  = DIV_W'(FOSC_DIV4 / 2 - 1);
   localparam logic [DIV_W-1:0] RELOAD_DIV16 = DIV_W'(FOSC_DIV16 / 2 - 1);
   localparam logic [DIV_W-1:0] RELOAD_DIV64 = DIV_W'(FOSC_DIV64 / 2 - 1);

   localparam int BITS_PER_XFER = 8;
   localparam logic [4:0] LAST_TICK = 5'(2 * BITS_PER_XFER);

   typedef enum logic {
      ST_IDLE  = 1'b0,
      ST_SHIFT = 1'b1
   } xfer_state_t;

   typedef struct packed {
      xfer_state_t      st;
      logic             write_collision_flag;
      logic             en;
      logic             clock_idle_polarity;
      logic [3:0]       mode;
      logic             sample_phase;
      logic             cke;
      logic             bf;
      logic             irq;
      logic [7:0]       buffer;
      logic [7:0]       shreg;
      logic [4:0]       ph;
      logic [DIV_W-1:0] div;
      logic             samp;
      logic             sck;
      logic             serial_data_out;
      logic [7:0]       rdata;
      logic             ser_en;
   } state_t;

endpackage

`default_nettype wire

// file: logic/spi_master_port.sv
// Notes on behaviour
// - eight bits out and in, MSb first
// - master drives every clock pulse
// - completed byte to buffer, set full, irq
// - buffer write while busy dropped, collision set
// - buffer read clears full flag
// - shift register reachable only through buffer
// - enabled master mode takes over serial pins
// - buffer write starts transfer at once
// - data-in still sampled for receive only
// - rate Fosc/4, /16, /64 or timer/2
// - clock idles at programmed polarity
// - edge select presents data before first edge
// - sample at middle or end of bit
// - sleep freezes transfer, resumes on wake
// - mode codes 0000 to 0011 pick rate
// - polarity one idles high, zero low
// - overflow flag never set as master
// - enable cleared releases the serial pins
//
// Added by the designer: the strobed register port and the address map.
`default_nettype none

module spi_master_port (
   input  wire logic                 mclk_i,
   input  wire logic                 nrst_i,
   input  wire spi_port_pkg::bus_req_t bus_i,
   input  wire logic                 sleep_i,
   input  wire logic                 tmr2_tick_i,
   input  wire logic                 sdi_i,
   output logic [7:0]                rdata_o,
   output logic                      sck_o,
   output logic                      sdo_o,
   output logic                      serial_en_o
);
   import spi_port_pkg::*;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   state_t           s_r;
   state_t           s_nxt;
   logic             active;
   logic             tick;
   logic             shift_now;
   logic             mid_now;
   logic             in_bit;
   logic             xfer_done;
   logic             buf_wr;
   logic             buf_rd;
   logic [DIV_W-1:0] reload;

   assign buf_wr = bus_i.we && (bus_i.addr == OFF_BUF);
   assign buf_rd = bus_i.re && (bus_i.addr == OFF_BUF);

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb
   begin
      s_nxt     = s_r;
      tick      = 1'b0;
      shift_now = 1'b0;
      mid_now   = 1'b0;
      in_bit    = 1'b0;
      xfer_done = 1'b0;
      // slave mode codes are not served here, so only 0000..0011 run
      active    = s_r.en && (s_r.mode <= MODE_TMR2);
      s_nxt.ser_en = active;
      s_nxt.rdata  = 8'h00;

      // rate select
      // timer mode ignores the divider, so its reload goes unused
      if (s_r.mode == MODE_DIV16)
      begin
         reload = RELOAD_DIV16;
      end
      else if (s_r.mode == MODE_DIV64)
      begin
         reload = RELOAD_DIV64;
      end
      else
      begin
         reload = RELOAD_DIV4;
      end

      // register reads; shift register has no address of its own
      if (bus_i.re)
      begin
         if (bus_i.addr == OFF_CTRL)
         begin
            // overflow bit reads zero: a master never overruns
            s_nxt.rdata = {s_r.write_collision_flag, 1'b0, s_r.en, s_r.clock_idle_polarity, s_r.mode};
         end
         else if (bus_i.addr == OFF_STAT)
         begin
            s_nxt.rdata = {s_r.sample_phase, s_r.cke, 5'h00, s_r.bf};
         end
         else if (bus_i.addr == OFF_BUF)
         begin
            s_nxt.rdata = s_r.buffer;
            s_nxt.bf    = 1'b0;
         end
         else if (bus_i.addr == OFF_IRQ)
         begin
            s_nxt.rdata = {4'h0, s_r.irq, 3'h0};
         end
         else
         begin
            s_nxt.rdata = 8'h00;
         end
      end

      // register writes
      if (bus_i.we)
      begin
         if (bus_i.addr == OFF_CTRL)
         begin
            // collision flag only cleared by software writing zero
            s_nxt.write_collision_flag = bus_i.wdata[CTRL_WRITE_COLLISION_FLAG];
            s_nxt.en   = bus_i.wdata[CTRL_EN];
            s_nxt.clock_idle_polarity  = bus_i.wdata[CTRL_CKP];
            s_nxt.mode = bus_i.wdata[3:0];
         end
         else if (bus_i.addr == OFF_STAT)
         begin
            s_nxt.sample_phase = bus_i.wdata[STAT_SMP];
            s_nxt.cke = bus_i.wdata[STAT_CKE];
         end
         else if (bus_i.addr == OFF_IRQ)
         begin
            s_nxt.irq = bus_i.wdata[IRQ_PORT];
         end
         else if (bus_i.addr == OFF_BUF)
         begin
            if (s_r.st == ST_SHIFT)
            begin
               s_nxt.write_collision_flag = 1'b1;
            end
            else
            begin
               s_nxt.buffer = bus_i.wdata;
               if (active)
               begin
                  s_nxt.shreg = bus_i.wdata;
                  s_nxt.st    = ST_SHIFT;
                  s_nxt.ph    = 5'h00;
                  s_nxt.div   = '0;
                  s_nxt.serial_data_out   = bus_i.wdata[7];
               end
            end
         end
      end

      // shift engine
      // sleep gates only this engine; the register bus keeps working
      if (!active)
      begin
         s_nxt.st  = ST_IDLE;
         s_nxt.sck = s_r.clock_idle_polarity;
      end
      else if (s_r.st == ST_IDLE)
      begin
         s_nxt.sck = s_r.clock_idle_polarity;
      end
      else if (!sleep_i)
      begin
         if (s_r.mode == MODE_TMR2)
         begin
            tick = tmr2_tick_i;
         end
         else
         begin
            tick      = (s_r.div == reload);
            s_nxt.div = tick ? '0 : DIV_W'(s_r.div + 1'b1);
         end
         if (tick)
         begin
            s_nxt.ph = 5'(s_r.ph + 1'b1);
            if (s_r.ph < LAST_TICK)
            begin
               s_nxt.sck = ~s_r.sck;
            end
            // edge select decides which half carries the data change
            shift_now = s_r.cke ? s_r.ph[0] : (!s_r.ph[0] && (s_r.ph != 5'h00));
            mid_now   = s_r.cke ? (!s_r.ph[0] && (s_r.ph < LAST_TICK)) : s_r.ph[0];
            in_bit    = s_r.sample_phase ? sdi_i : s_r.samp;
            if (mid_now)
            begin
               s_nxt.samp = sdi_i;
            end
            if (shift_now)
            begin
               s_nxt.shreg = {s_r.shreg[6:0], in_bit};
               s_nxt.serial_data_out   = s_r.shreg[6];
            end
            // completion sits last, so its set beats a same-cycle read or irq clear
            if (s_r.ph == LAST_TICK)
            begin
               xfer_done    = 1'b1;
               s_nxt.st     = ST_IDLE;
               s_nxt.buffer = s_nxt.shreg;
               s_nxt.bf     = 1'b1;
               s_nxt.irq    = 1'b1;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         s_r        <= '0;
         s_r.st     <= ST_IDLE;
         s_r.buffer <= BUF_RST;
         s_r.mode   <= CTRL_RST[3:0];
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign rdata_o     = s_r.rdata;
   assign sck_o       = s_r.sck;
   assign sdo_o       = s_r.serial_data_out;
   assign serial_en_o = s_r.ser_en;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!nrst_i);

   sequence s_done;
      xfer_done;
   endsequence

   sequence s_edge4;
      s_r.mode == MODE_DIV4 && s_r.st == ST_SHIFT && active && tick && s_r.ph < 5'd15 && !sleep_i;
   endsequence

   property p_start;
      buf_wr && active && s_r.st == ST_IDLE |=> s_r.st == ST_SHIFT && s_r.shreg == $past(bus_i.wdata);
   endproperty
   a_start: assert property (p_start) else $error("buffer write did not start transfer");

   property p_write_collision_flag;
      buf_wr && s_r.st == ST_SHIFT && !tick |=> s_r.write_collision_flag && $stable(s_r.shreg);
   endproperty
   a_write_collision_flag: assert property (p_write_collision_flag) else $error("busy write not flagged or not dropped");

   property p_done;
      s_done |=> s_r.bf && s_r.irq && s_r.st == ST_IDLE && s_r.buffer == s_r.shreg;
   endproperty
   a_done: assert property (p_done) else $error("completion did not load buffer and flags");

   property p_rd_clr;
      buf_rd && !xfer_done |=> !s_r.bf;
   endproperty
   a_rd_clr: assert property (p_rd_clr) else $error("buffer read left full flag set");

   // wired to zero; kept to catch a later remap of the control fields
   property p_ovf;
      bus_i.re && bus_i.addr == OFF_CTRL |=> !rdata_o[CTRL_OVF];
   endproperty
   a_ovf: assert property (p_ovf) else $error("overflow flag read as set");

   property p_idle;
      active && s_r.st == ST_IDLE && !buf_wr ##1 s_r.st == ST_IDLE |=> sck_o == $past(s_r.clock_idle_polarity);
   endproperty
   a_idle: assert property (p_idle) else $error("idle clock level wrong");

   property p_sleep;
      sleep_i && s_r.st == ST_SHIFT && active && !bus_i.we |=> $stable(s_r.shreg) && $stable(s_r.ph) && $stable(sck_o);
   endproperty
   a_sleep: assert property (p_sleep) else $error("transfer moved during sleep");

   property p_dis;
      !s_r.en |=> !serial_en_o && s_r.st == ST_IDLE;
   endproperty
   a_dis: assert property (p_dis) else $error("pins held while disabled");

   // a frozen cycle holds the divider, so the next one may still be quiet
   property p_div4;
      s_edge4 |=> !tick ##1 (tick || sleep_i || $past(sleep_i) || !active);
   endproperty
   a_div4: assert property (p_div4) else $error("fastest rate not two clocks per half bit");

   property p_cke;
      buf_wr && active && s_r.st == ST_IDLE && s_r.cke |=> sdo_o == $past(bus_i.wdata[7]);
   endproperty
   a_cke: assert property (p_cke) else $error("first data bit not presented early");

endmodule

`default_nettype wire

// file: verif/spi_slave_model.sv
`default_nettype none
module spi_slave_model (
   input  wire logic       mclk_i,
   input  wire logic       sel_i,
   input  wire logic       ckp_i,
   input  wire logic       cke_i,
   input  wire logic [7:0] tx_i,
   input  wire logic       sck_i,
   input  wire logic       sdo_i,
   output logic            sdi_o,
   output logic [7:0]      rx_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       sck_q;
   logic       sel_q;
   logic [7:0] tx_q;
   initial sdi_o = 1'h0;
   // ----------------------------------------
   // slave shifter, moves only on master clock
   // ----------------------------------------
   always @(posedge mclk_i)
   begin
      sck_q <= sck_i;
      sel_q <= sel_i;
      if (!sel_i)
      begin
         // unselected: toggling line, stale data never looks valid
         sdi_o <= ~sdi_o;
         tx_q  <= tx_i;
      end
      else if (!sel_q)
      begin
         // take the byte on select, so a byte set beside select is not missed
         sdi_o <= tx_i[7];
         tx_q  <= tx_i;
      end
      else if (sck_i != sck_q && (sck_i != ckp_i) == cke_i)
         rx_o <= {rx_o[6:0], sdo_i};
      else if (sck_i != sck_q)
      begin
         // change one clock after the launching edge, past end-of-bit sampling
         sdi_o <= cke_i ? tx_q[6] : tx_q[7];
         tx_q  <= {tx_q[6:0], 1'h0};
      end
   end
endmodule
`default_nettype wire

// file: verif/spi_master_port_test.sv
`default_nettype none
module spi_master_port_test;
   import spi_port_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic       mclk_i  = 1'h0;
   logic       nrst_i  = 1'h0;
   bus_req_t   bus     = '0;
   logic       sleep_i = 1'h0;
   logic       tick    = 1'h0;
   logic [1:0] tc      = 2'h0;
   logic       sel     = 1'h0;
   logic       clock_idle_polarity     = 1'h0;
   logic       cke     = 1'h0;
   logic [7:0] stx     = 8'h00;
   logic [7:0] srx;
   logic       serial_data_in;
   logic [7:0] rdata_o;
   logic       sck_o;
   logic       sdo_o;
   logic       serial_en_o;
   int         n_mismatch  = 0;
   int         check_count = 0;

   spi_master_port DUT (
      .mclk_i      (mclk_i),
      .nrst_i      (nrst_i),
      .bus_i       (bus),
      .sleep_i     (sleep_i),
      .tmr2_tick_i (tick),
      .sdi_i       (serial_data_in),
      .rdata_o     (rdata_o),
      .sck_o       (sck_o),
      .sdo_o       (sdo_o),
      .serial_en_o (serial_en_o)
   );
   spi_slave_model u_slave (
      .mclk_i (mclk_i),
      .sel_i  (sel),
      .ckp_i  (clock_idle_polarity),
      .cke_i  (cke),
      .tx_i   (stx),
      .sck_i  (sck_o),
      .sdo_i  (sdo_o),
      .sdi_o  (serial_data_in),
      .rx_o   (srx)
   );

   always #12.5 mclk_i = ~mclk_i;
   always @(posedge mclk_i)
   begin
      tc   <= tc + 2'h1;
      tick <= (tc == 2'h3);
   end

   // ----------------------------------------
   // bus and compare tasks
   // ----------------------------------------
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      check_count++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      bus.addr  <= a;
      bus.wdata <= d;
      bus.we    <= 1'h1;
      @(posedge mclk_i);
      bus.we <= 1'h0;
      #1;
   endtask
   task automatic rdc(input logic [3:0] a, input logic [7:0] e);
      bus.addr <= a;
      bus.re   <= 1'h1;
      @(posedge mclk_i);
      bus.re <= 1'h0;
      #1;
      chk(16'(rdata_o), 16'(e));
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset();
      chk(16'({sck_o, sdo_o, serial_en_o}), 16'h0);
      rdc(OFF_CTRL, CTRL_RST);
      rdc(OFF_STAT, 8'h00);
      rdc(OFF_BUF, BUF_RST);
      rdc(OFF_IRQ, 8'h00);
      wr(4'hF, 8'hFF);
      rdc(4'hF, 8'h00);
      rdc(OFF_CTRL, CTRL_RST);
   endtask
   task automatic t_en(input logic [7:0] v, input logic e);
      wr(OFF_CTRL, v);
      repeat (2) @(posedge mclk_i);
      #1;
      chk(16'(serial_en_o), 16'(e));
   endtask
   task automatic xfer(input logic [3:0] m, input logic p, input logic s, input logic k,
                       input logic [7:0] d, input logic [7:0] r, input int slp);
      int   n, hi, tg, half;
      logic lst, sl;
      half = (m == MODE_DIV4) ? FOSC_DIV4 / 2 : (m == MODE_DIV16) ? FOSC_DIV16 / 2 :
             (m == MODE_DIV64) ? FOSC_DIV64 / 2 : 4;
      hi = 0;
      tg = 0;
      wr(OFF_CTRL, {4'h0, m});
      wr(OFF_CTRL, {3'h1, p, m});
      wr(OFF_STAT, {s, k, 6'h00});
      clock_idle_polarity <= p;
      cke <= k;
      stx <= r;
      sel <= 1'h1;
      @(posedge mclk_i);
      #1;
      chk(16'(sck_o), 16'(p));
      chk(16'(serial_en_o), 16'h1);
      wr(OFF_BUF, d);
      chk(16'(sdo_o), 16'(d[7]));
      chk(16'(sck_o), 16'(p));
      wr(OFF_BUF, ~d);
      // a timer tick may already have launched the first edge here
      hi = int'(sck_o !== p);
      tg = hi;
      for (n = 0; n < 4000 && tg < 16; n++)
      begin
         lst = sck_o;
         sl  = sleep_i;
         @(posedge mclk_i);
         #1;
         sleep_i <= (n >= slp && n < slp + 40);
         if (sl)
            chk(16'(sck_o), 16'(lst));
         else if (sck_o !== p)
            hi++;
         if (sck_o !== lst)
            tg++;
      end
      repeat (80) @(posedge mclk_i);
      #1;
      sel <= 1'h0;
      chk(16'(tg), 16'h10);
      chk(16'(hi), 16'(8 * half));
      chk(16'(sck_o), 16'(p));
      rdc(OFF_STAT, {s, k, 6'h01});
      rdc(OFF_IRQ, 8'h08);
      wr(OFF_IRQ, 8'h00);
      rdc(OFF_IRQ, 8'h00);
      rdc(OFF_BUF, r);
      chk(16'(srx), 16'(d));
      rdc(OFF_STAT, {s, k, 6'h00});
      rdc(OFF_CTRL, {3'h5, p, m});
      wr(OFF_CTRL, {3'h1, p, m});
      rdc(OFF_CTRL, {3'h1, p, m});
   endtask

   initial
   begin
      repeat (6) @(posedge mclk_i);
      nrst_i <= 1'h1;
      @(posedge mclk_i);
      #1;
      t_reset();
      xfer(MODE_DIV4, 1'h0, 1'h0, 1'h1, 8'hA5, 8'h3C, 9999);
      xfer(MODE_DIV16, 1'h1, 1'h1, 1'h1, 8'h81, 8'hC3, 30);
      xfer(MODE_DIV64, 1'h0, 1'h1, 1'h1, 8'h7E, 8'h01, 9999);
      xfer(MODE_TMR2, 1'h1, 1'h0, 1'h1, 8'h5A, 8'hFE, 9999);
      xfer(MODE_DIV4, 1'h1, 1'h1, 1'h0, 8'hC6, 8'h6D, 9999);
      xfer(MODE_TMR2, 1'h0, 1'h0, 1'h0, 8'h39, 8'h92, 9999);
      t_en(8'h20, 1'h1);
      t_en(8'h00, 1'h0);
      t_en(8'h24, 1'h0);
      stop_test();
   end
   initial
   begin
      repeat (40000) @(posedge mclk_i);
      n_mismatch++;
      stop_test();
   end
endmodule
`default_nettype wire
